// ### cbh_consts.svh
`ifndef CBH_CONSTS_SVH
`define CBH_CONSTS_SVH

// ************************************************************
// bus cycle encodings
// ************************************************************
`define CBH_MIO_IO        1'b0
`define CBH_DC_DATA       1'b1
`define CBH_WR_WRITE      1'b1
`define CBH_WR_READ       1'b0

// ************************************************************
// address fields
// ************************************************************
`define CBH_LINE_LSB      5
`define CBH_ADDR_LSB      3
`define CBH_TAG_DEPTH     16
`define CBH_IDX_BITS      4
`define CBH_WB_BEATS      2'h3

// ************************************************************
// reset values
// ************************************************************
`define CBH_ADDR_RST      29'h0000_0000
`define CBH_BE_RST        8'hff

`endif

// ### cbh_pkg.sv
package cbh_pkg;
  // line coherency state
  typedef enum logic [1:0] {
    CBH_INVALID,
    CBH_SHARED,
    CBH_EXCLUSIVE,
    CBH_MODIFIED
  } cbh_line_e;

  // bus sequencer states
  typedef enum logic [2:0] {
    CBH_IDLE,
    CBH_ADDR,
    CBH_WAIT,
    CBH_HOLD,
    CBH_WBACK
  } cbh_bus_e;
endpackage

// ### cbh_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; a change counts once stages two and three agree
module cbh_sync (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // level
  input  wire logic i_d,
  input  wire logic i_rst_val,
  output logic      o_q
);
  logic [2:0] sh_reg;
  logic [2:0] sh_next;
  logic       q_reg;
  logic       q_next;

  // shift and filter
  always_comb begin
    sh_next = {sh_reg[1:0], i_d};
    q_next  = (sh_reg[2] == sh_reg[1]) ? sh_reg[2] : q_reg;
  end

  // registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sh_reg <= 3'h0;
      q_reg  <= 1'b0;
    end else begin
      sh_reg <= sh_next;
      q_reg  <= q_next;
    end
  end

  assign o_q = q_reg ^ i_rst_val;
endmodule

// ### cbh_tag_mem.sv
`timescale 1ns/1ps
`include "cbh_consts.svh"
// small line-tag memory: tag and state per index, registered read
module cbh_tag_mem
  import cbh_pkg::*;
(
  // clock and reset
  input  wire logic                         i_clk,
  input  wire logic                         i_rst,
  // read port
  input  wire logic [`CBH_IDX_BITS-1:0]     i_rd_idx,
  output logic [22:0]                       o_rd_tag,
  output cbh_line_e                         o_rd_state,
  // write port
  input  wire logic                         i_wr_en,
  input  wire logic [`CBH_IDX_BITS-1:0]     i_wr_idx,
  input  wire logic [22:0]                  i_wr_tag,
  input  cbh_line_e                         i_wr_state
);
  logic [22:0] tag_mem [`CBH_TAG_DEPTH];
  cbh_line_e   st_reg  [`CBH_TAG_DEPTH];
  logic [22:0] rd_tag_reg;
  cbh_line_e   rd_st_reg;

  // state array under reset, tags without
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < `CBH_TAG_DEPTH; k++) begin
        st_reg[k] <= CBH_INVALID;
      end
      rd_st_reg <= CBH_INVALID;
    end else begin
      if (i_wr_en) begin
        st_reg[i_wr_idx] <= i_wr_state;
      end
      rd_st_reg <= st_reg[i_rd_idx];
    end
  end

  // tag array and registered read
  always_ff @(posedge i_clk) begin
    if (i_wr_en) begin
      tag_mem[i_wr_idx] <= i_wr_tag;
    end
    rd_tag_reg <= tag_mem[i_rd_idx];
  end

  assign o_rd_tag   = rd_tag_reg;
  assign o_rd_state = rd_st_reg;
endmodule

// ### cbh_bus_unit.sv
`timescale 1ns/1ps
`include "cbh_consts.svh"
module cbh_bus_unit
  import cbh_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // core request side
  input  wire logic        i_req,
  input  wire logic        i_req_write,
  input  wire logic        i_req_split,
  input  wire logic [31:3] i_req_addr,
  input  wire logic [7:0]  i_req_be_lo_n,
  input  wire logic [7:0]  i_req_be_hi_n,
  input  wire logic [63:0] i_req_wdata,
  output logic             o_req_ready,
  output logic             o_rsp_valid,
  output logic [63:0]      o_rsp_rdata,
  // arbitration pins
  input  wire logic        i_burst_ready_n,
  input  wire logic        i_hold_req,
  input  wire logic        i_addr_hold_req,
  input  wire logic        i_backoff_n,
  output logic             o_bus_hold_ack,
  // inquire pins
  input  wire logic        i_ext_addr_strobe_n,
  input  wire logic        i_snoop_invalidate,
  output logic             o_snoop_hit_n,
  output logic             o_snoop_hit_modified_n,
  output logic             o_addr_parity_err_n,
  // address bus, two-way
  input  wire logic [31:3] i_addr,
  input  wire logic        i_addr_parity,
  output logic [31:3]      o_addr,
  output logic             o_addr_parity,
  output logic             o_addr_oe,
  // data bus and cycle outputs
  input  wire logic [63:0] i_data,
  output logic [63:0]      o_data,
  output logic [7:0]       o_data_parity,
  output logic             o_data_oe,
  output logic             o_addr_strobe_n,
  output logic [7:0]       o_byte_enable_n,
  output logic             o_mem_io_sel,
  output logic             o_data_code_sel,
  output logic             o_write_read_sel,
  output logic             o_split_cycle,
  output logic             o_page_cache_disable,
  output logic             o_page_write_through,
  output logic             o_ctl_oe
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic burst_ready_n_n;
  logic hold;
  logic addr_hold_req;
  logic backoff_n_n;
  logic ext_addr_strobe_n_n;
  logic snoop_invalidate;

  cbh_sync u_s_burst_ready_n (.i_clk(i_clk), .i_rst(i_rst), .i_d(~i_burst_ready_n), .i_rst_val(1'b1), .o_q(burst_ready_n_n));
  cbh_sync u_s_hold (.i_clk(i_clk), .i_rst(i_rst), .i_d(i_hold_req), .i_rst_val(1'b0), .o_q(hold));
  cbh_sync u_s_ahld (.i_clk(i_clk), .i_rst(i_rst), .i_d(i_addr_hold_req), .i_rst_val(1'b0), .o_q(addr_hold_req));
  cbh_sync u_s_backoff_n (.i_clk(i_clk), .i_rst(i_rst), .i_d(~i_backoff_n), .i_rst_val(1'b1), .o_q(backoff_n_n));
  cbh_sync u_s_ext_addr_strobe_n (.i_clk(i_clk), .i_rst(i_rst), .i_d(~i_ext_addr_strobe_n), .i_rst_val(1'b1), .o_q(ext_addr_strobe_n_n));
  cbh_sync u_s_inv  (.i_clk(i_clk), .i_rst(i_rst), .i_d(i_snoop_invalidate), .i_rst_val(1'b0), .o_q(snoop_invalidate));

  // ************************************************************
  // tag memory
  // ************************************************************
  logic [`CBH_IDX_BITS-1:0] rd_idx;
  logic [22:0]              rd_tag;
  cbh_line_e                rd_state;
  logic                     tw_en;
  logic [`CBH_IDX_BITS-1:0] tw_idx;
  cbh_line_e                tw_state;

  cbh_tag_mem u_tags (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_rd_idx   (rd_idx),
    .o_rd_tag   (rd_tag),
    .o_rd_state (rd_state),
    .i_wr_en    (tw_en),
    .i_wr_idx   (tw_idx),
    .i_wr_tag   (rd_tag),
    .i_wr_state (tw_state)
  );

  // even parity over address bits 31:3
  function automatic logic addr_par(input logic [31:3] a);
    addr_par = ^a;
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  cbh_bus_e    st_reg,     st_next;
  cbh_bus_e    ret_reg,    ret_next;   // state to resume after hold
  logic        pend_reg,   pend_next;  // a cycle is owed (new or aborted)
  logic        hi_reg,     hi_next;    // second half of split
  logic        split_reg,  split_next;
  logic        wr_reg,     wr_next;
  logic [31:3] a_reg,      a_next;
  logic [7:0]  belo_reg,   belo_next;
  logic [7:0]  behi_reg,   behi_next;
  logic [63:0] wd_reg,     wd_next;
  logic [63:0] rd_reg,     rd_next;
  logic        rv_reg,     rv_next;
  logic        ads_reg,    ads_next;
  logic        bus_hold_ack_reg,   bus_hold_ack_next;
  logic        ddrv_reg,   ddrv_next;
  logic        hit_reg,    hit_next;
  logic        snoop_hit_modified_n_reg,   snoop_hit_modified_n_next;
  logic        addr_parity_err_n_reg,  addr_parity_err_n_next;
  logic        look_reg,   look_next;  // tag read in flight
  logic        linv_reg,   linv_next;
  logic [31:5] sa_reg,     sa_next;    // latched inquire address
  logic        spar_reg,   spar_next;
  logic [1:0]  ahcnt_reg,  ahcnt_next;
  logic [1:0]  beat_reg,   beat_next;
  logic        wbq_reg,    wbq_next;   // writeback owed
  logic        eadsd_reg,  eadsd_next; // inquire strobe level one edge back

  assign rd_idx = i_addr[`CBH_LINE_LSB+`CBH_IDX_BITS-1:`CBH_LINE_LSB];

  // sequencer next state
  always_comb begin
    st_next    = st_reg;
    ret_next   = ret_reg;
    pend_next  = pend_reg;
    hi_next    = hi_reg;
    split_next = split_reg;
    wr_next    = wr_reg;
    a_next     = a_reg;
    belo_next  = belo_reg;
    behi_next  = behi_reg;
    wd_next    = wd_reg;
    rd_next    = rd_reg;
    rv_next    = 1'b0;
    ads_next   = 1'b0;
    bus_hold_ack_next  = bus_hold_ack_reg;
    ddrv_next  = ddrv_reg;
    hit_next   = hit_reg;
    snoop_hit_modified_n_next  = snoop_hit_modified_n_reg;
    addr_parity_err_n_next = 1'b0;
    look_next  = 1'b0;
    linv_next  = linv_reg;
    sa_next    = sa_reg;
    spar_next  = spar_reg;
    wbq_next   = wbq_reg;
    eadsd_next = ext_addr_strobe_n_n;
    beat_next  = beat_reg;
    tw_en      = 1'b0;
    tw_idx     = sa_reg[`CBH_LINE_LSB+`CBH_IDX_BITS-1:`CBH_LINE_LSB];
    tw_state   = CBH_INVALID;
    ahcnt_next = addr_hold_req ? ((ahcnt_reg == 2'h3) ? ahcnt_reg : ahcnt_reg + 2'h1) : 2'h0;

    // inquire strobe: address hold after two clocks, hold acknowledged, or back-off
    // only the falling edge counts, so a long strobe is one inquire
    if (!ext_addr_strobe_n_n && eadsd_reg && ((addr_hold_req && ahcnt_reg >= 2'h2) || (bus_hold_ack_reg && hold) || !backoff_n_n)) begin
      look_next = 1'b1;
      linv_next = snoop_invalidate;
      sa_next   = i_addr[31:5];
      spar_next = (addr_par(i_addr[31:3]) != i_addr_parity);
    end
    // compare result returns one edge later
    if (look_reg) begin
      if (rd_tag == sa_reg[31:9] && rd_state != CBH_INVALID) begin
        hit_next  = 1'b1;
        snoop_hit_modified_n_next = (rd_state == CBH_MODIFIED);
        wbq_next  = (rd_state == CBH_MODIFIED);
        tw_en     = 1'b1;
        tw_state  = linv_reg ? CBH_INVALID : CBH_SHARED;
      end else begin
        hit_next  = 1'b0;
        snoop_hit_modified_n_next = 1'b0;
      end
      addr_parity_err_n_next = spar_reg;
    end

    case (st_reg)
      CBH_IDLE: begin
        if (hold && !bus_hold_ack_reg && !wbq_reg) begin
          bus_hold_ack_next = 1'b1;
          ret_next  = CBH_IDLE;
          st_next   = CBH_HOLD;
        end else if (backoff_n_n && wbq_reg && !look_reg) begin
          st_next   = CBH_WBACK;
          a_next    = {sa_reg, 2'h0};
          wr_next   = `CBH_WR_WRITE;
          ads_next  = 1'b1;
          beat_next = 2'h0;
          ddrv_next = 1'b1;
        end else if (backoff_n_n && !wbq_reg && !look_reg && (pend_reg || i_req)) begin
          if (!pend_reg) begin
            pend_next  = 1'b1;
            hi_next    = 1'b0;
            split_next = i_req_split;
            wr_next    = i_req_write;
            a_next     = i_req_addr;
            belo_next  = i_req_be_lo_n;
            behi_next  = i_req_be_hi_n;
            wd_next    = i_req_wdata;
          end
          ads_next  = 1'b1;
          st_next   = CBH_ADDR;
        end
      end
      CBH_ADDR: begin
        ddrv_next = wr_reg;
        st_next   = CBH_WAIT;
      end
      CBH_WAIT, CBH_WBACK: begin
        if (!backoff_n_n) begin
          st_next   = CBH_IDLE;
          ddrv_next = 1'b0;
          if (st_reg == CBH_WBACK) begin
            wbq_next = 1'b1;
          end
        end else if (st_reg == CBH_WBACK) begin
          if (!burst_ready_n_n) begin
            beat_next = beat_reg + 2'h1;
            if (beat_reg == `CBH_WB_BEATS) begin
              st_next   = CBH_IDLE;
              wbq_next  = 1'b0;
              snoop_hit_modified_n_next = 1'b0;
              ddrv_next = 1'b0;
            end
          end
        end else if (!burst_ready_n_n) begin
          rd_next = i_data;
          if (split_reg && !hi_reg) begin
            hi_next  = 1'b1;
            ads_next = 1'b1;
            st_next  = CBH_ADDR;
            ddrv_next = wr_reg;
          end else begin
            rv_next   = 1'b1;
            pend_next = 1'b0;
            st_next   = CBH_IDLE;
            ddrv_next = 1'b0;
          end
        end
      end
      CBH_HOLD: begin
        if (!hold) begin
          bus_hold_ack_next = 1'b0;
          st_next   = ret_reg;
          if (backoff_n_n && !wbq_reg && pend_reg) begin
            ads_next = 1'b1;
            st_next  = CBH_ADDR;
          end
        end
      end
      default: st_next = CBH_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg    <= CBH_IDLE;
      ret_reg   <= CBH_IDLE;
      pend_reg  <= 1'b0;
      hi_reg    <= 1'b0;
      split_reg <= 1'b0;
      wr_reg    <= `CBH_WR_READ;
      a_reg     <= `CBH_ADDR_RST;
      belo_reg  <= `CBH_BE_RST;
      behi_reg  <= `CBH_BE_RST;
      wd_reg    <= 64'h0;
      rd_reg    <= 64'h0;
      rv_reg    <= 1'b0;
      ads_reg   <= 1'b0;
      bus_hold_ack_reg  <= 1'b0;
      ddrv_reg  <= 1'b0;
      hit_reg   <= 1'b0;
      snoop_hit_modified_n_reg  <= 1'b0;
      addr_parity_err_n_reg <= 1'b0;
      look_reg  <= 1'b0;
      linv_reg  <= 1'b0;
      sa_reg    <= 27'h0;
      spar_reg  <= 1'b0;
      ahcnt_reg <= 2'h0;
      beat_reg  <= 2'h0;
      wbq_reg   <= 1'b0;
      eadsd_reg <= 1'b1;
    end else begin
      st_reg    <= st_next;
      ret_reg   <= ret_next;
      pend_reg  <= pend_next;
      hi_reg    <= hi_next;
      split_reg <= split_next;
      wr_reg    <= wr_next;
      a_reg     <= a_next;
      belo_reg  <= belo_next;
      behi_reg  <= behi_next;
      wd_reg    <= wd_next;
      rd_reg    <= rd_next;
      rv_reg    <= rv_next;
      ads_reg   <= ads_next;
      bus_hold_ack_reg  <= bus_hold_ack_next;
      ddrv_reg  <= ddrv_next;
      hit_reg   <= hit_next;
      snoop_hit_modified_n_reg  <= snoop_hit_modified_n_next;
      addr_parity_err_n_reg <= addr_parity_err_n_next;
      look_reg  <= look_next;
      linv_reg  <= linv_next;
      sa_reg    <= sa_next;
      spar_reg  <= spar_next;
      ahcnt_reg <= ahcnt_next;
      beat_reg  <= beat_next;
      wbq_reg   <= wbq_next;
      eadsd_reg <= eadsd_next;
    end
  end

  // ************************************************************
  // pin outputs
  // ************************************************************
  logic bus_own;
  assign bus_own = !bus_hold_ack_reg && backoff_n_n;

  assign o_req_ready            = (st_reg == CBH_IDLE) && !pend_reg && backoff_n_n && !wbq_reg && !hold && !look_reg;
  assign o_rsp_valid            = rv_reg;
  assign o_rsp_rdata            = rd_reg;
  assign o_bus_hold_ack         = bus_hold_ack_reg;
  assign o_snoop_hit_n          = ~hit_reg;
  assign o_snoop_hit_modified_n = ~(snoop_hit_modified_n_reg && hit_reg);
  assign o_addr_parity_err_n    = ~addr_parity_err_n_reg;
  assign o_addr                 = a_reg;
  assign o_addr_parity          = addr_par(a_reg);
  assign o_addr_oe              = bus_own && !addr_hold_req;
  assign o_data                 = wd_reg;
  assign o_data_parity          = {^wd_reg[63:56], ^wd_reg[55:48], ^wd_reg[47:40], ^wd_reg[39:32],
                                   ^wd_reg[31:24], ^wd_reg[23:16], ^wd_reg[15:8], ^wd_reg[7:0]};
  assign o_data_oe              = bus_own && ddrv_reg;
  assign o_addr_strobe_n        = ~ads_reg;
  assign o_byte_enable_n        = hi_reg ? behi_reg : belo_reg;
  assign o_mem_io_sel           = `CBH_MIO_IO;
  assign o_data_code_sel        = `CBH_DC_DATA;
  assign o_write_read_sel       = wr_reg;
  assign o_split_cycle          = split_reg;
  assign o_page_cache_disable   = 1'b1;
  assign o_page_write_through   = 1'b1;
  assign o_ctl_oe               = bus_own;
endmodule

// ### cbh_bus_unit_monitor.sv
`timescale 1ns/1ps
// ************************************************************
// port checker for the bus unit
// ************************************************************
module cbh_mon (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // arbitration and inquire pins in
  input wire logic i_hold_req,
  input wire logic i_addr_hold_req,
  input wire logic i_backoff_n,
  input wire logic i_ext_addr_strobe_n,
  // pins out
  input wire logic o_bus_hold_ack,
  input wire logic o_snoop_hit_n,
  input wire logic o_snoop_hit_modified_n,
  input wire logic o_addr_parity_err_n,
  input wire logic o_addr_oe,
  input wire logic o_data_oe,
  input wire logic o_ctl_oe,
  input wire logic o_addr_strobe_n,
  input wire logic o_mem_io_sel,
  input wire logic o_data_code_sel,
  input wire logic o_write_read_sel
);
  logic [3:0] quiet_reg;
  logic [3:0] quiet_next;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // clocks since the last inquire strobe, saturating
  always_comb begin
    quiet_next = quiet_reg;
    if (!i_ext_addr_strobe_n) quiet_next = 4'h0;
    else if (quiet_reg != 4'hf) quiet_next = quiet_reg + 4'h1;
  end

  // register the quiet count
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) quiet_reg <= 4'h0;
    else quiet_reg <= quiet_next;
  end

  // bus rules seen at the pins
  AST_IO_TYPE: assert property (o_ctl_oe |-> !o_mem_io_sel && o_data_code_sel)
    else $error("cycle type is not io data");
  AST_STROBE_ONE: assert property ($fell(o_addr_strobe_n) |=> o_addr_strobe_n)
    else $error("strobe longer than one clock");
  AST_WR_DATA: assert property (!o_addr_strobe_n && o_write_read_sel |=> o_data_oe || !o_ctl_oe)
    else $error("write data not driven after strobe");
  AST_HOLD_WAIT: assert property (!o_addr_strobe_n |=> !o_bus_hold_ack)
    else $error("hold granted inside a cycle");
  AST_HOLD_FLOAT: assert property (o_bus_hold_ack |-> !o_addr_oe && !o_data_oe && !o_ctl_oe)
    else $error("bus driven during hold");
  AST_HOLD_DROP: assert property (!i_hold_req [*6] |-> !o_bus_hold_ack)
    else $error("hold ack kept after hold dropped");
  AST_HIT_PAIR: assert property (!o_snoop_hit_modified_n |-> !o_snoop_hit_n)
    else $error("modified hit without hit");
  AST_HIT_HOLD: assert property (quiet_reg >= 4'hc |-> $stable(o_snoop_hit_n))
    else $error("hit changed without inquire");
  AST_ADDR_HOLD_REQ_FLOAT: assert property (i_addr_hold_req [*6] |-> !o_addr_oe)
    else $error("address driven under address hold");
  AST_ADDR_HOLD_REQ_KEEP: assert property ((i_addr_hold_req && !i_hold_req && i_backoff_n) [*6] |-> o_ctl_oe)
    else $error("control floated under address hold");
  AST_PAR_PULSE: assert property ($fell(o_addr_parity_err_n) |=> o_addr_parity_err_n)
    else $error("parity check pulse not one clock");
  AST_BACKOFF_N_FLOAT: assert property (!i_backoff_n [*6] |-> !o_ctl_oe && !o_data_oe && !o_addr_oe)
    else $error("bus driven during back-off");

  // main scenarios reached
  COV_HOLD: cover property ($rose(o_bus_hold_ack));
  COV_PAR: cover property ($fell(o_addr_parity_err_n));
  COV_ADDR_HOLD_REQ: cover property (i_addr_hold_req && !o_addr_oe && !o_addr_strobe_n);
  COV_BACKOFF_N: cover property (!i_backoff_n && !o_ctl_oe);
endmodule

bind cbh_bus_unit cbh_mon u_mon (
  .i_clk(i_clk), .i_rst(i_rst), .i_hold_req(i_hold_req), .i_addr_hold_req(i_addr_hold_req),
  .i_backoff_n(i_backoff_n), .i_ext_addr_strobe_n(i_ext_addr_strobe_n), .o_bus_hold_ack(o_bus_hold_ack),
  .o_snoop_hit_n(o_snoop_hit_n), .o_snoop_hit_modified_n(o_snoop_hit_modified_n),
  .o_addr_parity_err_n(o_addr_parity_err_n), .o_addr_oe(o_addr_oe), .o_data_oe(o_data_oe),
  .o_ctl_oe(o_ctl_oe), .o_addr_strobe_n(o_addr_strobe_n), .o_mem_io_sel(o_mem_io_sel),
  .o_data_code_sel(o_data_code_sel), .o_write_read_sel(o_write_read_sel)
);

// ### cbh_sys_model.sv
`timescale 1ns/1ps
// ************************************************************
// system logic on the far side of the bus
// ************************************************************
module cbh_sys_model (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // device bus outputs and back-off
  input  wire logic        i_addr_strobe_n,
  input  wire logic        i_rsp_valid,
  input  wire logic        i_backoff_n,
  input  wire logic [31:3] i_addr,
  // wait states to insert
  input  wire logic [1:0]  i_wait,
  // answers
  output logic             o_burst_ready_n,
  output logic [63:0]      o_data
);
  logic        busy;
  logic        dv;     // read data still standing
  logic        rl;     // second clock of ready
  logic [1:0]  cnt;
  logic [31:3] addr;
  logic [31:0] pat;

  // count wait states after the strobe, then ready for two clocks so the filter sees it
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      busy <= 1'b0;
      dv <= 1'b0;
      rl <= 1'b0;
      o_burst_ready_n <= 1'b1;
      cnt <= 2'h0;
      addr <= '0;
      pat <= 32'h0;
    end else begin
      pat <= pat + 32'h1;
      if (!i_addr_strobe_n || !i_backoff_n) begin
        busy <= !i_addr_strobe_n && i_backoff_n;
        o_burst_ready_n <= 1'b1;
        rl <= 1'b0;
        dv <= 1'b0;
        cnt <= i_wait;
        if (!i_addr_strobe_n) addr <= i_addr;
      end else if (busy && cnt != 2'h0) begin
        cnt <= cnt - 2'h1;
      end else if (busy) begin
        busy <= 1'b0;
        rl <= 1'b1;
        dv <= 1'b1;
        o_burst_ready_n <= 1'b0;
      end else if (rl) begin
        rl <= 1'b0;
      end else begin
        o_burst_ready_n <= 1'b1;
        if (i_rsp_valid) dv <= 1'b0;
      end
    end
  end

  // read data stand until the answer, next strobe or back-off, a changing pattern otherwise
  assign o_data = dv ? {~{addr, 3'h0}, addr, 3'h0} : {pat, ~pat};
endmodule

// ### cbh_bus_unit_tb.sv
`timescale 1ns/1ps
`include "cbh_consts.svh"
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_count++; $display("ERROR %0t: got %h exp %h", $time, got, exp); end end
// ************************************************************
// bench for the bus unit
// ************************************************************
module cbh_bus_unit_tb;
  typedef struct packed {
    logic        chk;
    logic [31:3] a;
    logic [7:0]  be;
    logic        wr;
    logic [63:0] wd;
  } cbh_exp_s;
  logic        i_clk, i_rst, i_req, i_req_write, i_req_split, i_burst_ready_n, i_hold_req;
  logic        i_addr_hold_req, i_backoff_n, i_ext_addr_strobe_n, i_snoop_invalidate, i_addr_parity;
  logic        o_req_ready, o_rsp_valid, o_bus_hold_ack, o_snoop_hit_n, o_snoop_hit_modified_n;
  logic        o_addr_parity_err_n, o_addr_parity, o_addr_oe, o_data_oe, o_addr_strobe_n, o_mem_io_sel;
  logic        o_data_code_sel, o_write_read_sel, o_split_cycle, o_page_cache_disable;
  logic        o_page_write_through, o_ctl_oe, wd_pend, wd_chk;
  logic [31:3] i_req_addr, i_addr, o_addr;
  logic [7:0]  i_req_be_lo_n, i_req_be_hi_n, o_data_parity, o_byte_enable_n;
  logic [63:0] i_req_wdata, o_rsp_rdata, i_data, o_data, rnd, wd_val;
  logic [1:0]  wait_sel;
  logic [64:0] rsp_q[$], r;
  cbh_exp_s    exp_q[$], e;
  int          err_count = 0, total_checks = 0, cyc = 0;

  cbh_bus_unit dut (.*);
  cbh_sys_model u_sys (.i_clk(i_clk), .i_rst(i_rst), .i_addr_strobe_n(o_addr_strobe_n),
    .i_rsp_valid(o_rsp_valid), .i_backoff_n(i_backoff_n), .i_addr(o_addr), .i_wait(wait_sel),
    .o_burst_ready_n(i_burst_ready_n), .o_data(i_data));

  // clock
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task automatic finish_test();
    if (err_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  function automatic logic pick(input int i);
    case (i)
      0: return o_addr_strobe_n;
      1: return o_bus_hold_ack;
      2: return o_addr_parity_err_n;
      default: return o_addr_oe;
    endcase
  endfunction

  // wait for a device output, bounded
  task automatic wait_for(input int i, input logic v);
    int n;
    n = 0;
    while (pick(i) !== v && n < 300) begin
      @(posedge i_clk);
      n++;
    end
    #1;
    `CHECK(n < 300, 1'b1)
  endtask

  // one core access; notes expected strobes and answer
  task automatic do_req(input logic wr, sp, input logic [31:3] a, input logic [7:0] bl, bh,
                        input logic [63:0] wd);
    int n;
    exp_q.push_back({!sp, a, bl, wr, wd});
    if (sp) exp_q.push_back({1'b0, a, bh, wr, wd});
    rsp_q.push_back({!wr && !sp, ~{a, 3'h0}, a, 3'h0});
    {i_req, i_req_write, i_req_split, i_req_addr} = {1'b1, wr, sp, a};
    {i_req_be_lo_n, i_req_be_hi_n, i_req_wdata} = {bl, bh, wd};
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_req_ready !== 1'b1 && n < 300);
    #1 i_req = 1'b0;
    n = 0;
    while (rsp_q.size() != 0 && n < 300) begin
      @(posedge i_clk);
      n++;
    end
    #1;
  endtask

  // compare each strobe and answer against the oldest note
  always @(negedge i_clk) begin
    if (wd_pend) begin
      `CHECK(o_data_oe, 1'b1)
      if (wd_chk) `CHECK(o_data, wd_val)
    end
    wd_pend = 1'b0;
    if (!i_rst && o_addr_strobe_n === 1'b0) begin
      `CHECK(exp_q.size() != 0, 1'b1)
      if (exp_q.size() != 0) e = exp_q.pop_front();
      `CHECK({o_mem_io_sel, o_data_code_sel}, {`CBH_MIO_IO, `CBH_DC_DATA})
      `CHECK({o_byte_enable_n, o_write_read_sel}, {e.be, e.wr})
      if (e.chk && o_addr_oe) `CHECK(o_addr, e.a)
      {wd_pend, wd_chk, wd_val} = {e.wr, e.chk, e.wd};
    end
    if (o_rsp_valid === 1'b1 && rsp_q.size() != 0) begin
      r = rsp_q.pop_front();
      if (r[64]) `CHECK(o_rsp_rdata, r[63:0])
    end
  end

  // cut a hang short
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("ERROR %0t: run took too long", $time);
      finish_test();
    end
  end

  // main sequence
  initial begin
    {i_rst, i_req, i_req_write, i_req_split, i_hold_req, i_addr_hold_req} = 6'h20;
    {i_backoff_n, i_ext_addr_strobe_n, i_snoop_invalidate, i_addr_parity} = 4'hc;
    {i_req_addr, i_addr, i_req_be_lo_n, i_req_be_hi_n, i_req_wdata} = '0;
    {wait_sel, wd_pend} = 3'h0;
    void'($urandom(32'h49f9a8c8));
    repeat (6) @(posedge i_clk);
    #1 i_rst = 1'b0;
    // random traffic with every mix of read, write and split
    for (int k = 0; k < 16; k++) begin
      rnd = {$urandom, $urandom};
      wait_sel = rnd[41:40];
      do_req(k[0], k[1], rnd[31:3], rnd[7:0], rnd[15:8], {rnd[31:0], rnd[63:32]});
    end
    // hold during a slow write, then a hold inquire
    wait_sel = 2'h3;
    fork
      do_req(1'b1, 1'b0, 29'h0abc_1230, 8'hf0, 8'hff, 64'h0123_4567_89ab_cdef);
      begin
        wait_for(0, 1'b0);
        i_hold_req = 1'b1;
        wait_for(1, 1'b1);
        `CHECK(rsp_q.size(), 0)
      end
    join
    {i_addr, i_snoop_invalidate, i_ext_addr_strobe_n} = {29'h1555_0000, 2'h2};
    i_addr_parity = ^i_addr;
    tick(2);
    i_ext_addr_strobe_n = 1'b1;
    i_hold_req = 1'b0;
    wait_for(1, 1'b0);
    tick(8);
    `CHECK({o_snoop_hit_n, o_snoop_hit_modified_n}, 2'h3)
    // address hold, a bad-parity inquire, a split write under it
    i_addr_hold_req = 1'b1;
    tick(6);
    `CHECK(o_addr_oe, 1'b0)
    i_addr = 29'h0f0f_0f00;
    i_addr_parity = ~^i_addr;
    i_ext_addr_strobe_n = 1'b0;
    tick(2);
    i_ext_addr_strobe_n = 1'b1;
    wait_for(2, 1'b0);
    `CHECK(o_addr_parity_err_n, 1'b1)
    do_req(1'b1, 1'b1, 29'h0000_0101, 8'hc0, 8'hfc, 64'h5a5a_0000_a5a5_ffff);
    i_addr_hold_req = 1'b0;
    wait_for(3, 1'b1);
    // back-off aborts a slow read, which then restarts
    fork
      do_req(1'b0, 1'b0, 29'h0765_4328, 8'h00, 8'hff, 64'h0);
      begin
        wait_for(0, 1'b0);
        exp_q.push_back({1'b1, 29'h0765_4328, 8'h00, 1'b0, 64'h0});
        i_backoff_n = 1'b0;
        tick(6);
        `CHECK({o_ctl_oe, o_data_oe, o_addr_oe}, 3'h0)
        i_backoff_n = 1'b1;
      end
    join
    `CHECK(exp_q.size(), 0)
    finish_test();
  end
endmodule
